// ==== src/ipm_pkg.sv ====
`default_nettype none
// Shared constants for the pending, mode and mask block
package ipm_pkg;
    // Source map widths
    localparam int SRC_COUNT = 26;
    localparam int GLOBAL_BIT = 26;
    localparam int MASK_WIDTH = 28;
    localparam int EVT_WIDTH = 2;
    // Bit position of each source in pending, mode and mask
    localparam int SRC_EXTERNAL_LINE_ZERO = 25;
    localparam int SRC_EXTERNAL_LINE_ONE = 24;
    localparam int SRC_EXTERNAL_LINE_TWO = 23;
    localparam int SRC_EXTERNAL_LINE_THREE = 22;
    localparam int SRC_EXTERNAL_LINES_FOUR_TO_SEVEN = 21;
    localparam int SRC_TICK = 20;
    localparam int SRC_GENERAL_TRANSFER_ZERO = 19;
    localparam int SRC_GENERAL_TRANSFER_ONE = 18;
    localparam int SRC_BRIDGE_TRANSFER_ZERO = 17;
    localparam int SRC_BRIDGE_TRANSFER_ONE = 16;
    localparam int SRC_WATCHDOG = 15;
    localparam int SRC_SERIAL_ERROR = 14;
    localparam int SRC_TIMER_ZERO = 13;
    localparam int SRC_TIMER_ONE = 12;
    localparam int SRC_TIMER_TWO = 11;
    localparam int SRC_TIMER_THREE = 10;
    localparam int SRC_TIMER_FOUR = 9;
    localparam int SRC_TIMER_FIVE = 8;
    localparam int SRC_SERIAL_RECEIVE_ZERO = 7;
    localparam int SRC_SERIAL_RECEIVE_ONE = 6;
    localparam int SRC_TWO_WIRE_BUS = 5;
    localparam int SRC_SYNC_SERIAL = 4;
    localparam int SRC_SERIAL_TRANSMIT_ZERO = 3;
    localparam int SRC_SERIAL_TRANSMIT_ONE = 2;
    localparam int SRC_REAL_TIME_CLOCK = 1;
    localparam int SRC_CONVERTER = 0;
    // Byte addresses on the register bus
    localparam logic [31:0] ADDR_PENDING = 32'h01e0_0004;
    localparam logic [31:0] ADDR_MODE = 32'h01e0_0008;
    localparam logic [31:0] ADDR_MASK = 32'h01e0_000c;
    localparam logic [31:0] ADDR_NORMAL_CLEAR = 32'h01e0_0024;
    localparam logic [31:0] ADDR_CONFIG = 32'h01e0_0030;
    localparam logic [31:0] ADDR_FAST_CLEAR = 32'h01e0_0034;
    localparam logic [31:0] ADDR_EVT_STATUS = 32'h01e0_0038;
    localparam logic [31:0] ADDR_EVT_MASK = 32'h01e0_003c;
    // Values after reset, and the writable mask bits
    localparam logic [25:0] PENDING_RESET = 26'h000_0000;
    localparam logic [25:0] MODE_RESET = 26'h000_0000;
    localparam logic [27:0] MASK_RESET = 28'h7ff_ffff;
    localparam logic [27:0] MASK_WRITABLE = 28'h7ff_ffff;
    localparam logic NONVEC_RESET = 1'b1;
    localparam logic [1:0] EVT_RESET = 2'h0;
    localparam logic [1:0] EVT_MASK_RESET = 2'h3;
    // Event status bits
    localparam int EVT_NORMAL_OVERRUN = 0;
    localparam int EVT_FAST_OVERRUN = 1;
endpackage
`default_nettype wire

// ==== src/ipm_req_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Synchronised request levels from the input stage to the core
interface ipm_req_if;
    logic [ipm_pkg::SRC_COUNT-1:0] level;
    modport producer (output level);
    modport consumer (input level);
endinterface // ipm_req_if
`default_nettype wire

// ==== src/ipm_req_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipm_req_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Raw request lines from pins and peripherals
    input wire logic [ipm_pkg::SRC_COUNT-1:0] req_async,
    // Synchronised levels
    ipm_req_if.producer sync_o
);
    import ipm_pkg::*;

    // Fewer than two stages would let metastability reach the latches
    if (STAGES < 2) begin : g_bad
        $error("ipm_req_sync needs at least two stages");
    end

    // One flop chain per source; only the next stage reads a stage
    for (genvar i = 0; i < SRC_COUNT; i++) begin : g_src
        logic [STAGES-1:0] chain_r;
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                chain_r <= '0;
            end else begin
                chain_r <= {chain_r[STAGES-2:0], req_async[i]};
            end
        end
        assign sync_o.level[i] = chain_r[STAGES-1];
    end
endmodule // ipm_req_sync
`default_nettype wire

// ==== src/ipm_top.sv ====
// How it works
// RULE1 - One pending flag per source, 26 flags, set while the source requests.
// RULE2 - Writing one to a bit of either service clear register clears that flag.
// RULE3 - Simultaneous requests all set their own pending flags.
// RULE4 - Pending flags are set whatever the source mask says.
// RULE5 - Pending status is read only, one means requested, resets to zero.
// RULE6 - Pending, mode and mask share one bit map, bit 25 down to 0.
// RULE7 - Mode bit one routes a source to fast line, zero to normal line.
// RULE8 - Mode register reads and writes, resets to zero, all sources normal.
// RULE9 - Source mask bit one hides that source from the core.
// RULE10 - Global mask bit 26 hides every source, pending still latches.
// RULE11 - Mask register reads and writes, bit 27 reads zero, resets all masked.
// RULE12 - Vectored mode: masking does not hide a request already pending.
// RULE13 - Software clears the pending flag after masking in a vectored handler.
// RULE14 - Software masks a source only when it is not requesting.
// RULE15 - Software blocks everything with core status flags, not the mask.
// RULE16 - A normal service clear write clears the flags written as ones.
// RULE17 - Fast handler finds its source by reading pending status.
// RULE18 - Config bit zero vectored, one non-vectored; fast never vectored.
// RULE19 - Normal line follows unmasked pending mode-zero sources, fast mode-one.
`timescale 1ns/1ps
`default_nettype none
module ipm_top #(
    // Synchroniser depth for the raw request lines
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral and pin request lines
    input wire logic [ipm_pkg::SRC_COUNT-1:0] src_req,
    // Core request lines
    output logic normal_irq,
    output logic fast_irq,
    // Event interrupt
    output logic event_irq
);
    import ipm_pkg::*;

    // Fewer than two stages would let metastable levels reach the latches
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("ipm_top needs at least two synchroniser stages");
    end

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic normal_irq_r;
    logic fast_irq_r;
    logic event_irq_r;
    logic [25:0] pend_r;
    logic [25:0] mode_r;
    logic [27:0] mask_r;
    logic [25:0] hold_r;
    logic nonvec_r;
    logic [1:0] evt_r;
    logic [1:0] evt_en_r;
    logic [25:0] req_s;

    ipm_req_if req_bus ();

    // Pins and peripheral lines arrive unsynchronised
    ipm_req_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .req_async(src_req),
        .sync_o(req_bus.producer)
    );

    // Levels from the synchroniser, two edges behind the pins
    assign req_s = req_bus.level;

    // Bus phase and address decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_r;
    wire wr = access & pwrite;
    wire hit_pend = (paddr == ADDR_PENDING);
    wire hit_mode = (paddr == ADDR_MODE);
    wire hit_mask = (paddr == ADDR_MASK);
    wire hit_nclr = (paddr == ADDR_NORMAL_CLEAR);
    wire hit_fclr = (paddr == ADDR_FAST_CLEAR);
    wire hit_cfg = (paddr == ADDR_CONFIG);
    wire hit_evst = (paddr == ADDR_EVT_STATUS);
    wire hit_even = (paddr == ADDR_EVT_MASK);
    wire hit_any = hit_pend | hit_mode | hit_mask | hit_nclr | hit_fclr
                 | hit_cfg | hit_evst | hit_even;

    // Writes land only at the edge that completes the access phase
    wire wr_mode = wr & hit_mode;
    wire wr_mask = wr & hit_mask;
    wire wr_nclr = wr & hit_nclr;
    wire wr_fclr = wr & hit_fclr;
    wire wr_cfg = wr & hit_cfg;
    wire wr_evst = wr & hit_evst;
    wire wr_even = wr & hit_even;

    // Read mux; clear registers are write only and read as zero
    wire [31:0] rd_sel =
        hit_pend ? {6'h00, pend_r} :
        hit_mode ? {6'h00, mode_r} :
        hit_mask ? {4'h0, mask_r} :
        hit_cfg ? {31'h0, nonvec_r} :
        hit_evst ? {30'h0, evt_r} :
        hit_even ? {30'h0, evt_en_r} :
        32'h0000_0000;

    // Ones written to either clear register drop those pending flags
    wire [25:0] nclr_bits = wr_nclr ? pwdata[25:0] : 26'h000_0000; // RULE16
    wire [25:0] fclr_bits = wr_fclr ? pwdata[25:0] : 26'h000_0000;
    wire [25:0] clr_bits = nclr_bits | fclr_bits; // RULE2

    // Set beats clear so a request in the clearing cycle is kept
    wire [25:0] pend_nxt = (pend_r & ~clr_bits) | req_s; // RULE1 RULE3 RULE4

    // Mode and mask next values; reserved bit 27 never stores
    wire [25:0] mode_nxt = wr_mode ? pwdata[25:0] : mode_r; // RULE8
    wire [27:0] mask_nxt = wr_mask ? (pwdata[27:0] & MASK_WRITABLE)
                                   : mask_r; // RULE11

    // Flags whose mask bit rises in this mask write; pending and mode gate them below
    wire [25:0] newly_masked = wr_mask ? (pwdata[25:0] & ~mask_r[25:0])
                                       : 26'h000_0000;
    // Fast-routed flags are never held, fast service is never vectored
    wire [25:0] hold_nxt = nonvec_r ? 26'h000_0000
        : ((hold_r | (newly_masked & pend_r & ~mode_r)) & pend_nxt
           & ~mode_nxt); // RULE12 RULE18

    // A held flag bypasses its own mask bit, never the global bit
    wire [25:0] serviceable = pend_r & (~mask_r[25:0] | hold_r); // RULE9
    wire [25:0] active_normal = serviceable & ~mode_r; // RULE7
    wire [25:0] active_fast = serviceable & mode_r; // RULE7
    wire global_open = ~mask_r[GLOBAL_BIT]; // RULE10
    wire normal_nxt = global_open & (|active_normal); // RULE19
    wire fast_nxt = global_open & (|active_fast); // RULE19

    // A request arriving on a flag still pending is a lost event
    wire [25:0] overrun = req_s & pend_r & ~clr_bits;
    wire [1:0] evt_set = {|(overrun & mode_r), |(overrun & ~mode_r)};
    wire [1:0] evt_clr = wr_evst ? pwdata[1:0] : 2'h0;
    wire [1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

    // Bus answer: ready in the first cycle of the access phase, read data
    // snapshotted at the setup edge, error for unmapped addresses
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~hit_any;
            if (setup) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_sel;
            end
        end
    end

    // Pending latches; no write path, so the register stays read only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pend_r <= PENDING_RESET; // RULE5
        end else begin
            pend_r <= pend_nxt; // RULE6
        end
    end

    // Software controlled state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MODE_RESET; // RULE8
            mask_r <= MASK_RESET; // RULE11
            nonvec_r <= NONVEC_RESET;
            evt_en_r <= EVT_MASK_RESET;
        end else begin
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
            if (wr_cfg) begin
                nonvec_r <= pwdata[0]; // RULE18
            end
            if (wr_even) begin
                evt_en_r <= pwdata[1:0];
            end
        end
    end

    // Held flags and sticky events
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold_r <= 26'h000_0000;
            evt_r <= EVT_RESET;
        end else begin
            hold_r <= hold_nxt;
            evt_r <= evt_nxt;
        end
    end

    // Registered request lines cost one cycle of latency but stay glitch free
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            normal_irq_r <= 1'b0;
            fast_irq_r <= 1'b0;
            event_irq_r <= 1'b0;
        end else begin
            normal_irq_r <= normal_nxt;
            fast_irq_r <= fast_nxt;
            event_irq_r <= |(evt_r & evt_en_r);
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign normal_irq = normal_irq_r;
    assign fast_irq = fast_irq_r;
    assign event_irq = event_irq_r;

    // Checks on the registered state
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_pend_set_all: assert property ( // RULE1 RULE3 RULE4
        (req_s != 26'h000_0000)
        |=> ((pend_r & $past(req_s)) == $past(req_s)))
        else $error("requested source did not latch pending");

    chk_pend_no_spur: assert property ( // RULE5
        ##1 ((pend_r & ~$past(pend_r) & ~$past(req_s)) == 26'h000_0000))
        else $error("pending flag rose without a request");

    chk_clear_drops: assert property ( // RULE2 RULE16
        (wr_nclr || wr_fclr)
        |=> ((pend_r & $past(clr_bits) & ~$past(req_s)) == 26'h000_0000))
        else $error("service clear write left flag pending");

    chk_mode_write: assert property ( // RULE8
        wr_mode |=> (mode_r == $past(pwdata[25:0])))
        else $error("mode register did not take written value");

    chk_mask_reserved: assert property ( // RULE11
        (access && !pwrite && hit_mask) |-> (prdata_r[31:27] == 5'h00))
        else $error("mask read shows reserved bits set");

    chk_fast_route: assert property ( // RULE7
        $rose(fast_irq_r)
        |-> $past(|(pend_r & mode_r & ~mask_r[25:0])))
        else $error("fast line rose without unmasked fast source");

    chk_normal_route: assert property ( // RULE19
        normal_irq_r
        |-> ($past(|(pend_r & ~mode_r)) && !$past(mask_r[GLOBAL_BIT])))
        else $error("normal line high without pending normal source");

    chk_global_block: assert property ( // RULE10
        mask_r[GLOBAL_BIT] |=> (!normal_irq_r && !fast_irq_r))
        else $error("request reached core under global mask");

    chk_src_mask: assert property ( // RULE9
        ((pend_r & ~mask_r[25:0]) == 26'h000_0000
            && hold_r == 26'h000_0000)
        |=> (!normal_irq_r && !fast_irq_r))
        else $error("masked source reached the core");

    chk_vector_hold: assert property ( // RULE12
        (!nonvec_r && wr_mask && !pwdata[GLOBAL_BIT]
            && !mask_r[GLOBAL_BIT]
            && (|(pwdata[25:0] & ~mask_r[25:0] & pend_r
                & ~mode_r)))
        |=> ##1 normal_irq_r)
        else $error("latched vectored request was masked");

    chk_nonvec_hold: assert property ( // RULE18
        nonvec_r |=> (hold_r == 26'h000_0000))
        else $error("held flag kept in non-vectored mode");

    // Bus answer timing and the event line
    chk_apb_answer: assert property (
        setup |=> (pready_r ##1 !pready_r))
        else $error("bus answer not exactly one cycle after setup");

    chk_event_irq: assert property (
        (|(evt_r & evt_en_r)) |=> event_irq_r)
        else $error("enabled event did not raise event interrupt");

    // Flags only leave through a service clear
    chk_pend_keep: assert property ( // RULE1 RULE2
        ##1 (($past(pend_r) & ~$past(clr_bits) & ~pend_r)
            == 26'h000_0000))
        else $error("pending flag dropped without a clear");

    // Register file reads and writes
    chk_pend_read: assert property ( // RULE5
        (setup && !pwrite && hit_pend)
        |=> (prdata_r == {6'h00, $past(pend_r)}))
        else $error("pending read did not return the flags");

    chk_mode_read: assert property ( // RULE8
        (setup && !pwrite && hit_mode)
        |=> (prdata_r == {6'h00, $past(mode_r)}))
        else $error("mode read did not return the register");

    chk_mask_write: assert property ( // RULE11
        wr_mask |=> (mask_r == ($past(pwdata[27:0]) & MASK_WRITABLE)))
        else $error("mask register did not take written value");

    chk_cfg_write: assert property ( // RULE18
        wr_cfg |=> (nonvec_r == $past(pwdata[0])))
        else $error("vectoring bit did not take written value");

    // Open paths must reach the core one cycle later
    chk_fast_open: assert property ( // RULE7
        (!mask_r[GLOBAL_BIT] && (|(pend_r & mode_r & ~mask_r[25:0])))
        |=> fast_irq_r)
        else $error("unmasked fast source did not reach the core");

    chk_normal_open: assert property ( // RULE19
        (!mask_r[GLOBAL_BIT] && (|(pend_r & ~mode_r & ~mask_r[25:0])))
        |=> normal_irq_r)
        else $error("unmasked normal source did not reach the core");

    // Refused accesses change nothing and are flagged
    chk_bad_write: assert property (
        (wr && !hit_any)
        |=> ($stable(mode_r) && $stable(mask_r) && $stable(nonvec_r)))
        else $error("write to unmapped address changed a register");

    chk_error_flag: assert property (
        setup |=> (pslverr_r == !$past(hit_any)))
        else $error("error flag does not match the address decode");

    // A repeat on a still pending flag is a lost event
    chk_overrun_event: assert property (
        (|(req_s & pend_r & ~clr_bits & ~mode_r))
        |=> evt_r[EVT_NORMAL_OVERRUN])
        else $error("normal overrun not recorded");

    chk_fast_overrun: assert property (
        (|(req_s & pend_r & ~clr_bits & mode_r))
        |=> evt_r[EVT_FAST_OVERRUN])
        else $error("fast overrun not recorded");

    // Main scenarios
    cov_multi_req: cover property (
        $countones(req_s & ~pend_r) >= 2);
    cov_fast_irq: cover property ($rose(fast_irq_r));
    cov_hold_used: cover property (
        hold_r != 26'h000_0000 ##1 normal_irq_r);
    cov_bus_error: cover property (pslverr_r && pready_r);
    cov_vector_mask: cover property (wr_mask && !nonvec_r);
endmodule // ipm_top
`default_nettype wire

// ==== verification/ipm_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Peripheral side: request lines raised as levels, changed just after an edge
module ipm_src_model (
    // Clock
    input wire logic mclk,
    // Request levels towards the block
    output logic [ipm_pkg::SRC_COUNT-1:0] src_req
);
    import ipm_pkg::*;

    // Quiet lines until a scenario asks for a request
    initial begin
        src_req = '0;
    end

    // Hold of one cycle is a prompt source, longer holds a slow one
    task automatic pulse(input logic [SRC_COUNT-1:0] bits, input int hold);
        @(posedge mclk);
        src_req <= bits;
        repeat (hold) @(posedge mclk);
        src_req <= '0;
    endtask
endmodule // ipm_src_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ipm_pkg::*;
    // Bench drive and observation
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, normal_irq, fast_irq, event_irq;
    logic [SRC_COUNT-1:0] src_req;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;

    always #5 mclk = ~mclk;

    ipm_top i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .normal_irq(normal_irq), .fast_irq(fast_irq),
        .event_irq(event_irq));
    ipm_src_model i_src (.mclk(mclk), .src_req(src_req));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge mclk);
            n++;
        end
        if (pready !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Prompt request, then time for sync, latch and line update
    task automatic pulse_src(input logic [SRC_COUNT-1:0] bits);
        i_src.pulse(bits, 1);
        repeat (6) @(posedge mclk);
    endtask

    task automatic lines(input logic [31:0] exp);
        repeat (2) @(posedge mclk);
        check({30'h0, normal_irq, fast_irq}, exp);
    endtask

    task automatic sc_reset();
        rd_chk(ADDR_PENDING, 32'h0);
        rd_chk(ADDR_MODE, 32'h0);
        rd_chk(ADDR_MASK, 32'h07ff_ffff);
        rd_chk(ADDR_CONFIG, 32'h1);
        rd_chk(ADDR_EVT_MASK, 32'h3);
        check({29'h0, normal_irq, fast_irq, event_irq}, 32'h0);
    endtask

    // Register access kinds, reserved bit and an unmapped place
    task automatic sc_access();
        wr(ADDR_MASK, 32'hffff_ffff);
        rd_chk(ADDR_MASK, 32'h07ff_ffff);
        wr(ADDR_MASK, 32'h0);
        rd_chk(ADDR_MASK, 32'h0);
        wr(ADDR_MODE, 32'hffff_ffff);
        rd_chk(ADDR_MODE, 32'h03ff_ffff);
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_PENDING, 32'h03ff_ffff);
        rd_chk(ADDR_PENDING, 32'h0);
        apb(1'b1, 32'h01e0_0040, 32'h1);
        check({31'h0, err}, 32'h1);
        rd_chk(32'h01e0_0040, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(ADDR_MASK, 32'h07ff_ffff);
    endtask

    // Every source at once while all is masked
    task automatic sc_latch();
        pulse_src(26'h3ff_ffff);
        rd_chk(ADDR_PENDING, 32'h03ff_ffff);
        check({30'h0, normal_irq, fast_irq}, 32'h0);
        wr(ADDR_NORMAL_CLEAR, 32'h03ff_ffff);
        rd_chk(ADDR_PENDING, 32'h0);
    endtask

    // Bit positions at both ends of the map, and a partial clear
    task automatic sc_map();
        int pos [4] = '{SRC_EXTERNAL_LINE_ZERO,
            SRC_EXTERNAL_LINES_FOUR_TO_SEVEN, SRC_REAL_TIME_CLOCK,
            SRC_CONVERTER};
        logic [31:0] exp [4] = '{32'h0200_0000, 32'h0020_0000, 32'h2,
            32'h1};
        for (int i = 0; i < 4; i++) begin
            pulse_src(26'h1 << pos[i]);
            rd_chk(ADDR_PENDING, exp[i]);
            wr(ADDR_FAST_CLEAR, exp[i]);
        end
        pulse_src(26'h200_0001);
        wr(ADDR_NORMAL_CLEAR, 32'h0200_0000);
        rd_chk(ADDR_PENDING, 32'h1);
        wr(ADDR_FAST_CLEAR, 32'h1);
        rd_chk(ADDR_PENDING, 32'h0);
    endtask

    // Fast and normal steering, source mask, then global mask; a real
    // handler blocks everything at the core, the global bit is only probed
    task automatic sc_route();
        wr(ADDR_MODE, 32'h20);
        wr(ADDR_MASK, 32'h0);
        pulse_src(26'h20);
        lines(32'h1);
        rd_chk(ADDR_PENDING, 32'h20);
        wr(ADDR_FAST_CLEAR, 32'h20);
        lines(32'h0);
        pulse_src(26'h40);
        lines(32'h2);
        wr(ADDR_MASK, 32'h40);
        lines(32'h0);
        wr(ADDR_MASK, 32'h0400_0000);
        lines(32'h0);
        pulse_src(26'h20);
        rd_chk(ADDR_PENDING, 32'h60);
        wr(ADDR_MASK, 32'h0);
        lines(32'h3);
        wr(ADDR_NORMAL_CLEAR, 32'h60);
        lines(32'h0);
        wr(ADDR_MASK, 32'h07ff_ffff);
        wr(ADDR_MODE, 32'h0);
    endtask

    // Masking after latch in vectored operation does not hide it
    task automatic sc_vector();
        wr(ADDR_CONFIG, 32'h0);
        wr(ADDR_MASK, 32'h0);
        pulse_src(26'h80);
        wr(ADDR_MASK, 32'h80);
        lines(32'h2);
        wr(ADDR_NORMAL_CLEAR, 32'h80);
        lines(32'h0);
        wr(ADDR_CONFIG, 32'h1);
        wr(ADDR_MASK, 32'h07ff_ffff);
    endtask

    // Overrun event raised by a slow repeat, then masked and cleared
    task automatic sc_event();
        pulse_src(26'h2);
        i_src.pulse(26'h2, 3);
        repeat (6) @(posedge mclk);
        rd_chk(ADDR_EVT_STATUS, 32'h1);
        check({31'h0, event_irq}, 32'h1);
        wr(ADDR_EVT_MASK, 32'h0);
        repeat (3) @(posedge mclk);
        check({31'h0, event_irq}, 32'h0);
        wr(ADDR_EVT_MASK, 32'h3);
        wr(ADDR_EVT_STATUS, 32'h1);
        repeat (3) @(posedge mclk);
        check({31'h0, event_irq}, 32'h0);
        rd_chk(ADDR_EVT_STATUS, 32'h0);
        wr(ADDR_MODE, 32'h2);
        pulse_src(26'h2);
        rd_chk(ADDR_EVT_STATUS, 32'h2);
        wr(ADDR_EVT_STATUS, 32'h2);
        rd_chk(ADDR_EVT_STATUS, 32'h0);
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_NORMAL_CLEAR, 32'h2);
    endtask

    // Main sequence, with a second reset over latched requests
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        sc_reset();
        sc_access();
        sc_latch();
        sc_map();
        sc_route();
        sc_vector();
        sc_event();
        pulse_src(26'h3ff_ffff);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        sc_reset();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
